// ===== ebrc_map.vh
`ifndef EBRC_MAP_VH
`define EBRC_MAP_VH

// oscillator periods per state time
`define EBRC_OSC_PER_STATE 2'h2
// last state index of a bus cycle (three states)
`define EBRC_LAST_STATE 2'h2
// states in the reset sequence after release
`define EBRC_RESET_STATES 4'ha
// configuration byte and first opcode addresses
`define EBRC_CFG_ADDR 16'h2018
`define EBRC_BOOT_ADDR 16'h2080
// configuration byte fields and reset value
`define EBRC_CFG_BUS16_BIT 1
`define EBRC_CFG_WRSTB_BIT 2
`define EBRC_CFG_RST 8'h00
// prefetch queue
`define EBRC_Q_DEPTH 3'h4
`define EBRC_Q_AW 2
`define EBRC_Q_WORDS 4

`endif

// ===== ebrc_state_div.v
`timescale 1ns/1ps
`include "ebrc_map.vh"

module ebrc_state_div (
  input wire clk,
  input wire resetn,
  output reg state_end
);
  reg [1:0] osc_cnt;
  wire [1:0] last = `EBRC_OSC_PER_STATE - 2'h1;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_cnt <= 2'h0;
      state_end <= 1'b0;
    end else begin
      osc_cnt <= (osc_cnt == last) ? 2'h0 : osc_cnt + 2'h1;
      state_end <= (osc_cnt == last - 2'h1);
    end
  end
endmodule

// ===== ebrc_queue_mem.v
`timescale 1ns/1ps
`include "ebrc_map.vh"

module ebrc_queue_mem (
  input wire clk,
  input wire we,
  input wire [`EBRC_Q_AW-1:0] waddr,
  input wire [15:0] wdata,
  input wire [`EBRC_Q_AW-1:0] raddr,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:`EBRC_Q_WORDS-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== ebrc_bus_ctrl.v
// What this block does
// - high-enable (outside sixteen-bit strobe mode) and fetch flag held whole cycle
// - config byte read, then fetch from boot
// - config byte selects width and strobe mode
// - address strobe high while reset held
// - external access pin caught at release
// - sixteen-bit write strobe one period longer
// - eight-bit write strobes keep old width
// - fetch into full queue dropped, refetched
// - state time is two oscillator periods
// - eight-bit strobe mode: high pin marks even
// - low write strobe used for every byte outside sixteen-bit strobe mode
`timescale 1ns/1ps
`include "ebrc_map.vh"

module ebrc_bus_ctrl (
  input wire clk,
  input wire resetn,
  input wire external_access_sel_n,
  input wire [15:0] ad_in,
  output reg [15:0] ad_out,
  output reg ad_oe,
  output reg address_valid_n,
  output reg read_strobe_n,
  output reg write_low_strobe_n,
  output reg byte_high_enable_n,
  output reg instruction_fetch_flag,
  output reg external_mode,
  output reg bus16_mode,
  output reg write_strobe_mode,
  output reg seq_running,
  input wire data_req,
  input wire data_we,
  input wire data_byte,
  input wire [15:0] data_addr,
  input wire [15:0] data_wdata,
  output reg data_done,
  output reg [15:0] data_rdata,
  input wire fetch_flush,
  input wire [15:0] fetch_flush_addr,
  input wire instr_ready,
  output reg instr_valid,
  output reg [15:0] instr_data
);
  localparam [3:0] SEQ_LATCH = 4'h1;
  localparam [3:0] SEQ_CFG = 4'h2;
  localparam [3:0] SEQ_WAIT = 4'h4;
  localparam [3:0] SEQ_RUN = 4'h8;
  localparam [2:0] OP_CFG = 3'h1;
  localparam [2:0] OP_DATA = 3'h2;
  localparam [2:0] OP_FETCH = 3'h4;
  localparam [7:0] CFG_RST = `EBRC_CFG_RST;

  function lane_hi;
    input [15:0] a;
    input b16;
    input wbyte;
    begin
      lane_hi = b16 & (~wbyte | a[0]);
    end
  endfunction

  wire state_end;
  wire [15:0] q_rdata;
  reg [3:0] seq;
  reg [3:0] rst_states;
  reg busy;
  reg [1:0] st;
  reg [2:0] op;
  reg [15:0] cur_addr;
  reg cur_we;
  reg cur_byte;
  reg cur_second;
  reg [15:0] cur_wdata;
  reg [7:0] low_byte;
  reg drop;
  reg [15:0] fetch_addr;
  reg [`EBRC_Q_AW:0] wptr;
  reg [`EBRC_Q_AW:0] rptr;
  reg rd_pend;

  ebrc_state_div u_div (
    .clk(clk),
    .resetn(resetn),
    .state_end(state_end)
  );

  wire [2:0] q_count = wptr - rptr;
  wire q_full = (q_count == `EBRC_Q_DEPTH);
  wire adr_ph = busy & (st == 2'h0);
  wire cyc_end = busy & state_end & (st == `EBRC_LAST_STATE);
  wire last_osc = state_end & (st == `EBRC_LAST_STATE);
  wire cur_hi = lane_hi(cur_addr, bus16_mode, cur_byte);
  wire cur_lo = ~bus16_mode | ~cur_byte | ~cur_addr[0];
  wire word8 = ~bus16_mode & ~cur_byte;
  wire last_part = ~word8 | cur_second;
  wire [7:0] in_byte = (bus16_mode & cur_addr[0]) ? ad_in[15:8] : ad_in[7:0];
  wire [15:0] rd_word = word8 ? {in_byte, low_byte} :
                        (cur_byte ? {8'h00, in_byte} : ad_in);
  wire q_push = cyc_end & (op == OP_FETCH) & last_part & ~drop & ~q_full & ~fetch_flush;
  wire q_issue = (q_count != 3'h0) & ~rd_pend & (~instr_valid | instr_ready) & ~fetch_flush;
  wire start_ok = ~busy & state_end;
  wire want_cfg = (seq == SEQ_CFG);
  wire want_data = (seq == SEQ_RUN) & data_req & ~data_done;
  wire want_fetch = (seq == SEQ_RUN);

  ebrc_queue_mem u_mem (
    .clk(clk),
    .we(q_push),
    .waddr(wptr[`EBRC_Q_AW-1:0]),
    .wdata(rd_word),
    .raddr(rptr[`EBRC_Q_AW-1:0]),
    .rdata(q_rdata)
  );

  // reset sequence
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seq <= SEQ_LATCH;
      rst_states <= 4'h0;
      external_mode <= 1'b0;
      bus16_mode <= CFG_RST[`EBRC_CFG_BUS16_BIT];
      write_strobe_mode <= CFG_RST[`EBRC_CFG_WRSTB_BIT];
      seq_running <= 1'b0;
    end else begin
      if (state_end && rst_states != `EBRC_RESET_STATES) begin
        rst_states <= rst_states + 4'h1;
      end
      case (seq)
        SEQ_LATCH: begin
          external_mode <= ~external_access_sel_n;
          seq <= SEQ_CFG;
        end
        SEQ_CFG: begin
          if (cyc_end && op == OP_CFG) begin
            bus16_mode <= rd_word[`EBRC_CFG_BUS16_BIT];
            write_strobe_mode <= rd_word[`EBRC_CFG_WRSTB_BIT];
            seq <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (rst_states == `EBRC_RESET_STATES) begin
            seq <= SEQ_RUN;
            seq_running <= 1'b1;
          end
        end
        SEQ_RUN: begin
          seq <= SEQ_RUN;
        end
        default: begin
          seq <= SEQ_LATCH;
        end
      endcase
    end
  end

  // bus cycle engine
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      st <= 2'h0;
      op <= OP_CFG;
      cur_addr <= 16'h0000;
      cur_we <= 1'b0;
      cur_byte <= 1'b0;
      cur_second <= 1'b0;
      cur_wdata <= 16'h0000;
      low_byte <= 8'h00;
      drop <= 1'b0;
      fetch_addr <= `EBRC_BOOT_ADDR;
      data_done <= 1'b0;
      data_rdata <= 16'h0000;
    end else begin
      data_done <= 1'b0;
      if (fetch_flush) begin
        fetch_addr <= fetch_flush_addr;
        drop <= busy & (op == OP_FETCH);
      end
      if (busy && state_end) begin
        st <= st + 2'h1;
      end
      if (cyc_end) begin
        if (!last_part) begin
          low_byte <= in_byte;
          cur_second <= 1'b1;
          cur_addr <= cur_addr + 16'h0001;
          st <= 2'h0;
        end else begin
          busy <= 1'b0;
          cur_second <= 1'b0;
          drop <= 1'b0;
          if (op == OP_DATA) begin
            data_done <= 1'b1;
            data_rdata <= rd_word;
          end
          // advance only when the word was kept
          if (op == OP_FETCH && q_push) begin
            fetch_addr <= fetch_addr + 16'h0002;
          end
        end
      end else if (start_ok && (want_cfg || want_fetch)) begin
        busy <= 1'b1;
        st <= 2'h0;
        cur_second <= 1'b0;
        if (want_cfg) begin
          op <= OP_CFG;
          cur_addr <= `EBRC_CFG_ADDR;
          cur_we <= 1'b0;
          cur_byte <= 1'b1;
        end else if (want_data) begin
          op <= OP_DATA;
          cur_addr <= data_addr;
          cur_we <= data_we;
          cur_byte <= data_byte;
          cur_wdata <= data_wdata;
        end else begin
          // fetch even when the queue is full
          op <= OP_FETCH;
          cur_addr <= fetch_flush ? fetch_flush_addr : fetch_addr;
          cur_we <= 1'b0;
          cur_byte <= 1'b0;
        end
      end
    end
  end

  // prefetch queue pointers and output stage
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      rd_pend <= 1'b0;
      instr_valid <= 1'b0;
      instr_data <= 16'h0000;
    end else if (fetch_flush) begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      rd_pend <= 1'b0;
      instr_valid <= 1'b0;
    end else begin
      if (q_push) begin
        wptr <= wptr + 3'h1;
      end
      rd_pend <= q_issue;
      if (q_issue) begin
        rptr <= rptr + 3'h1;
      end
      if (rd_pend) begin
        instr_valid <= 1'b1;
        instr_data <= q_rdata;
      end else if (instr_ready) begin
        instr_valid <= 1'b0;
      end
    end
  end

  // pin values
  reg next_wstrobe;
  reg next_wrl_n;
  reg next_bhe_n;
  reg [15:0] next_ad;
  always @* begin
    // sixteen-bit strobe runs to the last period
    // eight-bit strobe ends one period early
    next_wstrobe = busy & cur_we & ~adr_ph & (bus16_mode | ~last_osc);
    if (adr_ph) begin
      next_ad = cur_addr;
    end else if (bus16_mode && cur_byte && cur_addr[0]) begin
      next_ad = {cur_wdata[7:0], cur_wdata[7:0]};
    end else if (word8 && cur_second) begin
      next_ad = {8'h00, cur_wdata[15:8]};
    end else begin
      next_ad = cur_wdata;
    end
    if (!write_strobe_mode) begin
      next_wrl_n = ~next_wstrobe;
      // level held for the whole cycle
      next_bhe_n = ~(busy & cur_hi);
    end else if (!bus16_mode) begin
      // low strobe for odd and even bytes
      next_wrl_n = ~next_wstrobe;
      // low for odd, high for even
      next_bhe_n = busy ? ~cur_addr[0] : 1'b1;
    end else begin
      next_wrl_n = ~(next_wstrobe & cur_lo);
      next_bhe_n = ~(next_wstrobe & cur_hi);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      address_valid_n <= 1'b1;
      ad_out <= 16'h0000;
      ad_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_low_strobe_n <= 1'b1;
      byte_high_enable_n <= 1'b1;
      instruction_fetch_flag <= 1'b0;
    end else begin
      address_valid_n <= adr_ph;
      ad_out <= next_ad;
      ad_oe <= busy & (adr_ph | cur_we);
      read_strobe_n <= ~(busy & ~adr_ph & ~cur_we);
      write_low_strobe_n <= next_wrl_n;
      byte_high_enable_n <= next_bhe_n;
      // fetch flag held for the whole cycle
      instruction_fetch_flag <= busy & (op == OP_FETCH);
    end
  end
endmodule

// ===== ebrc_bus_asserts.sv
`timescale 1ns/1ps
module ebrc_bus_asserts (
  input wire clk,
  input wire resetn,
  input wire [15:0] ad_out,
  input wire ad_oe,
  input wire address_valid_n,
  input wire read_strobe_n,
  input wire write_low_strobe_n,
  input wire byte_high_enable_n,
  input wire instruction_fetch_flag,
  input wire external_mode,
  input wire bus16_mode,
  input wire write_strobe_mode,
  input wire seq_running
);
  reg odd;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // parity of the address in flight
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      odd <= 1'b0;
    end else if (address_valid_n && ad_oe) begin
      odd <= ad_out[0];
    end
  end
  a_adv_in_reset: assert property (disable iff (1'b0) !resetn |-> address_valid_n)
    else $error("address strobe low in reset");
  a_ea_held: assert property (seq_running |-> $stable(external_mode))
    else $error("external mode changed");
  a_fetch_whole: assert property ($rose(instruction_fetch_flag) && bus16_mode |->
    instruction_fetch_flag [*6] ##1 !instruction_fetch_flag)
    else $error("fetch flag width");
  a_fetch8_whole: assert property ($rose(instruction_fetch_flag) && !bus16_mode |->
    instruction_fetch_flag [*6] ##1 instruction_fetch_flag [*6] ##1 !instruction_fetch_flag)
    else $error("byte bus fetch flag width");
  a_bhe_steady: assert property (!read_strobe_n && !$past(read_strobe_n) |->
    $stable(byte_high_enable_n) && $stable(instruction_fetch_flag))
    else $error("cycle flags moved");
  a_rd_width: assert property ($fell(read_strobe_n) |->
    !read_strobe_n [*4] ##1 read_strobe_n)
    else $error("read strobe width");
  a_wr16_width: assert property ($fell(write_low_strobe_n) && bus16_mode |->
    !write_low_strobe_n [*4] ##1 write_low_strobe_n)
    else $error("wide write strobe width");
  a_wr8_width: assert property ($fell(write_low_strobe_n) && !bus16_mode |->
    !write_low_strobe_n [*3] ##1 write_low_strobe_n)
    else $error("narrow write strobe width");
  a_hi_lane_odd: assert property (write_strobe_mode && !bus16_mode &&
    !write_low_strobe_n |-> byte_high_enable_n == !odd)
    else $error("high enable parity");
endmodule
bind ebrc_bus_ctrl ebrc_bus_asserts chk_u (.clk, .resetn, .ad_out, .ad_oe, .address_valid_n,
  .read_strobe_n, .write_low_strobe_n, .byte_high_enable_n, .instruction_fetch_flag,
  .external_mode, .bus16_mode, .write_strobe_mode, .seq_running);

// ===== ebrc_mem_model.sv
`timescale 1ns/1ps
module ebrc_mem_model (
  input wire clk,
  input wire [7:0] cfg,
  input wire [15:0] ad_out,
  input wire ad_oe,
  input wire address_valid_n,
  input wire read_strobe_n,
  input wire write_low_strobe_n,
  input wire byte_high_enable_n,
  output reg [15:0] ad_in,
  output reg [15:0] wr_addr,
  output reg [15:0] wr_data,
  output reg wr_bhe_n,
  output reg [7:0] wr_cnt
);
  reg [15:0] addr = 16'h0000;
  reg wl_q = 1'b1;
  initial ad_in = 16'h0000;
  initial wr_cnt = 8'h00;
  always @(posedge clk) begin
    wl_q <= write_low_strobe_n;
    if (address_valid_n && ad_oe) begin
      addr <= ad_out;
    end
    if (!read_strobe_n && addr >= 16'h2020 && addr < 16'h2080) begin
      ad_in <= 16'hffff;
    end else if (!read_strobe_n && addr == 16'h2018) begin
      ad_in <= {8'hff, cfg};
    end else if (!read_strobe_n) begin
      ad_in <= {addr[7:1], 1'b1, addr[7:0]} ^ 16'h3c3c;
    end else begin
      ad_in <= ~ad_in;
    end
    if (!write_low_strobe_n) begin
      wr_addr <= addr;
      wr_data <= ad_out;
      wr_bhe_n <= byte_high_enable_n;
    end
    if (!write_low_strobe_n && wl_q) begin
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg resetn = 1'b1;
  reg ea_n = 1'b1;
  reg req = 1'b0;
  reg we = 1'b0;
  reg byt = 1'b0;
  reg [15:0] addr = 16'h0000;
  reg [15:0] wdata = 16'h0000;
  reg flush = 1'b0;
  reg [15:0] faddr = 16'h0000;
  reg rdy = 1'b0;
  reg [7:0] cfg = 8'h00;
  reg [15:0] w;
  reg [15:0] base;
  wire [15:0] ad_in, ad_out, rdata, idata, wa, wd;
  wire [7:0] wcnt;
  wire oe, adv_n, rd_n, wl_n, bhe_n, ifl, xm, b16, wsm, run, done, ival, wbhe;
  integer err_count = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i;
  integer n;
  always #12.5 clk = ~clk;
  ebrc_bus_ctrl dut_u (.clk(clk), .resetn(resetn), .external_access_sel_n(ea_n),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(oe), .address_valid_n(adv_n),
    .read_strobe_n(rd_n), .write_low_strobe_n(wl_n), .byte_high_enable_n(bhe_n),
    .instruction_fetch_flag(ifl), .external_mode(xm), .bus16_mode(b16),
    .write_strobe_mode(wsm), .seq_running(run), .data_req(req), .data_we(we),
    .data_byte(byt), .data_addr(addr), .data_wdata(wdata), .data_done(done),
    .data_rdata(rdata), .fetch_flush(flush), .fetch_flush_addr(faddr),
    .instr_ready(rdy), .instr_valid(ival), .instr_data(idata));
  ebrc_mem_model mem_u (.clk(clk), .cfg(cfg), .ad_out(ad_out), .ad_oe(oe),
    .address_valid_n(adv_n), .read_strobe_n(rd_n), .write_low_strobe_n(wl_n),
    .byte_high_enable_n(bhe_n), .ad_in(ad_in), .wr_addr(wa), .wr_data(wd),
    .wr_bhe_n(wbhe), .wr_cnt(wcnt));
  function [15:0] wat(input [15:0] a);
    wat = {a[7:1], 1'b1, a[7:0]} ^ 16'h3c3c;
  endfunction
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task do_reset(input [7:0] c, input e);
    begin
      @(posedge clk);
      resetn <= 1'b0;
      cfg <= c;
      ea_n <= e;
      repeat (3) @(posedge clk);
      chk("adv in reset", 16'h1, {15'h0, adv_n});
      resetn <= 1'b1;
      for (n = 0; n < 400 && !(adv_n && oe); n = n + 1) @(posedge clk);
      chk("cfg addr", 16'h2018, ad_out);
      for (n = 0; n < 400 && !(adv_n && oe && ifl); n = n + 1) @(posedge clk);
      chk("boot addr", 16'h2080, ad_out);
      chk("ext mode", {15'h0, !e}, {15'h0, xm});
      chk("modes", {14'h0, c[2], c[1]}, {14'h0, wsm, b16});
    end
  endtask
  task bus_op(input wr, input b, input [15:0] a, input [15:0] d);
    begin
      @(posedge clk);
      req <= 1'b1;
      we <= wr;
      byt <= b;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      for (n = 0; n < 400 && !done; n = n + 1) @(posedge clk);
      req <= 1'b0;
    end
  endtask
  task take;
    begin
      @(posedge clk);
      for (n = 0; n < 400 && !ival; n = n + 1) @(posedge clk);
      w = idata;
    end
  endtask
  task t_fetch;
    begin
      do_reset(8'h06, 1'b1);
      repeat (200) @(posedge clk);
      rdy <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        take;
        chk("queued word", wat(16'h2080 + {i[14:0], 1'b0}), w);
      end
      rdy <= 1'b0;
      @(posedge clk);
      flush <= 1'b1;
      faddr <= 16'h3000;
      @(posedge clk);
      flush <= 1'b0;
      rdy <= 1'b1;
      take;
      chk("flushed word", wat(16'h3000), w);
      bus_op(1'b1, 1'b0, 16'h0600, 16'h5aa5);
      chk("lane strobe data", 16'h5aa5, wd);
      chk("lane strobe high", 16'h0, {15'h0, wbhe});
      $display("test fetch done");
    end
  endtask
  task t_word16;
    begin
      do_reset(8'h02, 1'b0);
      ea_n <= 1'b1;
      bus_op(1'b1, 1'b0, 16'h0400, 16'h1234);
      chk("wr addr", 16'h0400, wa);
      chk("wr data", 16'h1234, wd);
      bus_op(1'b0, 1'b0, 16'h0402, 16'h0000);
      chk("rd word", wat(16'h0402), rdata);
      chk("ext held", 16'h1, {15'h0, xm});
      $display("test word16 done");
    end
  endtask
  task t_byte8;
    begin
      do_reset(8'h04, 1'b1);
      base = {8'h00, wcnt};
      bus_op(1'b1, 1'b1, 16'h0301, 16'h00a7);
      chk("odd byte", 16'h00a7, {8'h00, wd[7:0]});
      chk("odd high enable", 16'h0, {15'h0, wbhe});
      bus_op(1'b1, 1'b1, 16'h0300, 16'h005e);
      chk("even byte", 16'h005e, {8'h00, wd[7:0]});
      chk("even high enable", 16'h1, {15'h0, wbhe});
      chk("low strobes", base + 16'h2, {8'h00, wcnt});
      bus_op(1'b0, 1'b0, 16'h0500, 16'h0000);
      chk("rd8 word", wat(16'h0500), rdata);
      $display("test byte8 done");
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  initial begin
    resetn <= 1'b0;
    t_fetch;
    t_word16;
    t_byte8;
    end_sim;
  end
endmodule
